// >>> design/sdio_port.sv
`timescale 1ns/1ns
module sdio_port
  import sdio_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [11:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [1:0] be_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  // Configuration logic ownership and values per line
  input wire logic [SDIO_W-1:0] cfg_owns_in,
  input wire logic [SDIO_W-1:0] cfg_oe_in,
  // Pins
  input wire logic [SDIO_W-1:0] pin_in,
  output logic [SDIO_W-1:0] pin_out,
  output logic [SDIO_W-1:0] pin_oe_out,
  // Status
  output logic shift_busy_out
);
  logic [1:0] rst_sync_q;
  wire rst_b = rst_sync_q[1];

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Pins are asynchronous: two stages before use
  logic [SDIO_W-1:0] pin_s1_q;
  logic [SDIO_W-1:0] pin_s2_q;
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Decode
  wire hit_out = (addr_in == SDIO_OFS_OUT);
  wire hit_ctrl = (addr_in == SDIO_OFS_CTRL);
  wire hit_pin_in = (addr_in == SDIO_OFS_PIN_IN);
  wire hit_sh_in = (addr_in == SDIO_OFS_SHIFT_IN);
  wire wr_par = wr_in && hit_out && be_in[0];
  wire wr_ser = wr_in && hit_out && be_in[1];
  wire wr_ctl_lo = wr_in && hit_ctrl && be_in[0];
  wire wr_ctl_hi = wr_in && hit_ctrl && be_in[1];

  logic [SDIO_W-1:0] par_q;
  logic [SDIO_W-1:0] ser_q;
  logic [SDIO_W-1:0] tx_q;
  logic [SDIO_W-1:0] rx_q;
  logic [SDIO_W-1:0] shin_q;
  sdio_ctrl_t ctrl_q;
  sdio_state_t st_q;
  sdio_state_t st_d;
  logic [3:0] cnt_q;
  logic sclk_q;
  logic sw_clk_q;
  sdio_pins_t pins_q;
  sdio_pins_t pins_d;

  wire idle = (st_q == SDIO_IDLE);
  // A go while busy is dropped, not queued
  wire go_cmd = wr_ctl_hi && wdata_in[SDIO_BIT_GO] && idle;
  wire start = go_cmd && wdata_in[SDIO_BIT_AUTO];
  wire tick;
  wire last = (cnt_q == SDIO_BITS - 4'h1);

  sdio_rate_div u_div (
    .clock_in(clock_in),
    .rst_b_in(rst_b),
    .run_in(!idle),
    .limit_in(ctrl_q.rate ? SDIO_SLOW_LIM : SDIO_FAST_LIM),
    .tick_out(tick)
  );

  // Low half presents data, rising edge samples input
  always_comb begin
    st_d = st_q;
    case (st_q)
      SDIO_IDLE: begin
        if (start) begin
          st_d = SDIO_LOW;
        end
      end
      SDIO_LOW: begin
        if (tick) begin
          st_d = SDIO_HIGH;
        end
      end
      SDIO_HIGH: begin
        if (tick) begin
          st_d = last ? SDIO_IDLE : SDIO_LOW;
        end
      end
      default: begin
        st_d = SDIO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      par_q <= '0;
      ser_q <= '0;
      ctrl_q <= '0;
    end else begin
      if (wr_par) begin
        par_q <= wdata_in[7:0];
      end
      if (wr_ser) begin
        ser_q <= wdata_in[15:8];
      end
      if (wr_ctl_lo) begin
        ctrl_q.drive_en <= wdata_in[7:0];
      end
      if (wr_ctl_hi) begin
        ctrl_q.toggle <= wdata_in[SDIO_BIT_TOGGLE];
        ctrl_q.rate <= wdata_in[SDIO_BIT_RATE];
        ctrl_q.auto_en <= wdata_in[SDIO_BIT_AUTO];
      end
      // Go shows as busy on shift_busy_out, clearing when the shift ends
      ctrl_q.go <= (st_d != SDIO_IDLE);
    end
  end

  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SDIO_IDLE;
      cnt_q <= '0;
      sclk_q <= 1'b0;
      tx_q <= '0;
      rx_q <= '0;
      shin_q <= '0;
      sw_clk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (start) begin
        tx_q <= ser_q;
        cnt_q <= '0;
      end else if (tick && st_q == SDIO_LOW) begin
        sclk_q <= 1'b1;
        rx_q <= {pin_s2_q[SDIO_LINE_SDAT], rx_q[SDIO_W-1:1]};
      end else if (tick && st_q == SDIO_HIGH) begin
        sclk_q <= 1'b0;
        tx_q <= {1'b0, tx_q[SDIO_W-1:1]};
        cnt_q <= cnt_q + 4'h1;
        if (last) begin
          // Last sample already taken on the rising half
          shin_q <= rx_q;
        end
      end
      if (wr_ctl_hi && !wdata_in[SDIO_BIT_AUTO] &&
          wdata_in[SDIO_BIT_TOGGLE]) begin
        sw_clk_q <= !sw_clk_q;
      end
    end
  end

  // Pin drive
  wire auto_now = ctrl_q.auto_en;
  always_comb begin
    pins_d.dout = par_q;
    if (auto_now) begin
      pins_d.dout[SDIO_LINE_SCLK] = sclk_q;
      pins_d.dout[SDIO_LINE_SDAT] = idle ? par_q[SDIO_LINE_SDAT] : tx_q[0];
    end else begin
      pins_d.dout[SDIO_LINE_SCLK] = par_q[SDIO_LINE_SCLK] ^ sw_clk_q;
    end
    // Configuration logic wins where it owns the line
    pins_d.oe = (cfg_owns_in & cfg_oe_in) |
                (~cfg_owns_in & ctrl_q.drive_en);
  end

  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign pin_out = pins_q.dout;
  assign pin_oe_out = pins_q.oe;
  assign shift_busy_out = ctrl_q.go;

  // Read side; write-only registers read as zero
  wire [15:0] rd_mux = hit_pin_in ? {8'h00, pin_s2_q} :
                       hit_sh_in ? {8'h00, shin_q} :
                       SDIO_RD_UNMAPPED;
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      rdata_out <= '0;
      rvalid_out <= 1'b0;
    end else begin
      rdata_out <= rd_in ? rd_mux : 16'h0000;
      rvalid_out <= rd_in;
    end
  end

  a_go_busy: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    start |=> shift_busy_out)
    else $error("busy not set after go");

  a_busy_drop: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    go_cmd && !wdata_in[SDIO_BIT_AUTO] |=> !shift_busy_out)
    else $error("busy without auto shift");

  a_busy_state: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    shift_busy_out == !idle)
    else $error("busy flag out of step with shifter");

  a_par_drive: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    wr_par && !ctrl_q.auto_en && !wr_ctl_hi
    |=> ##1 pin_out[7:5] == $past(wdata_in[7:5], 2))
    else $error("parallel out not driven");

  a_ser_load: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    wr_ser |=> ser_q == $past(wdata_in[15:8]))
    else $error("serial byte not loaded");

  a_oe_owned: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    ##1 pin_oe_out == $past((cfg_owns_in & cfg_oe_in) |
        (~cfg_owns_in & ctrl_q.drive_en)))
    else $error("output enable wrong");

  a_clock_line: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    ctrl_q.auto_en |=> pin_out[SDIO_LINE_SCLK] == $past(sclk_q))
    else $error("shift clock not on its line");

  a_data_line: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    ctrl_q.auto_en && !idle |=> pin_out[SDIO_LINE_SDAT] == $past(tx_q[0]))
    else $error("serial data not on its line");

  a_sclk_idle: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    idle |-> !sclk_q)
    else $error("shift clock not idle");

  a_bit_count: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    cnt_q <= SDIO_BITS)
    else $error("bit count overrun");

  a_fast_rate: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    $rose(sclk_q) && !ctrl_q.rate |-> ##12 $fell(sclk_q))
    else $error("fast half period wrong");

  a_fast_low: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    $fell(sclk_q) && !idle && !ctrl_q.rate |-> ##12 $rose(sclk_q))
    else $error("fast low half wrong");

  a_slow_rate: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    $rose(sclk_q) && ctrl_q.rate |-> ##100 $fell(sclk_q))
    else $error("slow half period wrong");

  a_shin_hold: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    !idle && !(st_q == SDIO_HIGH && tick && last) |=> $stable(shin_q))
    else $error("shift input changed mid shift");

  a_shin_load: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    st_q == SDIO_HIGH && tick && last |=> shin_q == $past(rx_q))
    else $error("received byte not stored");

  a_rd_strobe: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    rd_in |=> rvalid_out)
    else $error("read answer missing");

  a_rd_blank: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    rd_in && !hit_pin_in && !hit_sh_in |=> rdata_out == SDIO_RD_UNMAPPED)
    else $error("write-only register read back");

  a_pin_read: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    rd_in && hit_pin_in |=> rdata_out == {8'h00, $past(pin_s2_q)})
    else $error("pin read wrong");

  a_sw_toggle: assert property (
    @(posedge clock_in) disable iff (!rst_b)
    wr_ctl_hi && wdata_in[SDIO_BIT_TOGGLE] && !wdata_in[SDIO_BIT_AUTO]
    |=> sw_clk_q != $past(sw_clk_q))
    else $error("manual toggle missed");
endmodule

// >>> design/sdio_pkg.sv
package sdio_pkg;
  localparam int SDIO_W = 8;
  localparam logic [11:0] SDIO_OFS_PIN_IN = 12'h00E;
  localparam logic [11:0] SDIO_OFS_OUT = 12'h014;
  localparam logic [11:0] SDIO_OFS_CTRL = 12'h016;
  localparam logic [11:0] SDIO_OFS_SHIFT_IN = 12'h038;
  localparam int SDIO_BIT_GO = 8;
  localparam int SDIO_BIT_AUTO = 9;
  localparam int SDIO_BIT_RATE = 10;
  localparam int SDIO_BIT_TOGGLE = 11;
  localparam int SDIO_LINE_SCLK = 4;
  localparam int SDIO_LINE_SDAT = 0;
  localparam int SDIO_CLK_HZ = 20000000;
  localparam int SDIO_FAST_PERIOD_NS = 1200;
  localparam int SDIO_SLOW_HZ = 100000;
  // Half periods in clock cycles; shift clock toggles on each
  localparam int SDIO_FAST_HALF =
    (SDIO_FAST_PERIOD_NS * (SDIO_CLK_HZ / 1000000)) / 2000;
  localparam int SDIO_SLOW_HALF = SDIO_CLK_HZ / SDIO_SLOW_HZ / 2;
  localparam int SDIO_DIV_W = 8;
  localparam logic [SDIO_DIV_W-1:0] SDIO_FAST_LIM =
    SDIO_DIV_W'(SDIO_FAST_HALF - 1);
  localparam logic [SDIO_DIV_W-1:0] SDIO_SLOW_LIM =
    SDIO_DIV_W'(SDIO_SLOW_HALF - 1);
  localparam logic [3:0] SDIO_BITS = 4'h8;
  localparam logic [15:0] SDIO_RD_UNMAPPED = 16'h0000;

  typedef struct packed {
    logic toggle;
    logic rate;
    logic auto_en;
    logic go;
    logic [SDIO_W-1:0] drive_en;
  } sdio_ctrl_t;

  typedef struct packed {
    logic [SDIO_W-1:0] dout;
    logic [SDIO_W-1:0] oe;
  } sdio_pins_t;

  typedef enum logic [2:0] {
    SDIO_IDLE = 3'b001,
    SDIO_LOW = 3'b010,
    SDIO_HIGH = 3'b100
  } sdio_state_t;
endpackage

// >>> design/sdio_rate_div.sv
`timescale 1ns/1ns
module sdio_rate_div
  import sdio_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Control
  input wire logic run_in,
  input wire logic [SDIO_DIV_W-1:0] limit_in,
  // Tick
  output logic tick_out
);
  logic [SDIO_DIV_W-1:0] cnt_q;
  logic [SDIO_DIV_W-1:0] cnt_d;
  wire at_lim = (cnt_q >= limit_in);

  assign cnt_d = (!run_in || at_lim) ? '0 : cnt_q + 1'b1;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_out <= run_in && at_lim;
    end
  end
endmodule

// >>> verification/sdio_line_model.sv
`timescale 1ns/1ns
module sdio_line_model
  import sdio_pkg::*;
(
  // Port side
  input wire logic [SDIO_W-1:0] pin_out_in,
  input wire logic [SDIO_W-1:0] pin_oe_in,
  output logic [SDIO_W-1:0] pin_in_out,
  // Test control and observation
  input wire logic clear_in,
  input wire logic [SDIO_W-1:0] rx_byte_in,
  input wire logic [SDIO_W-1:0] idle_in,
  output logic [SDIO_W-1:0] tx_seen_out,
  output int rises_out
);
  logic data_bit;
  // Undriven lines show the far side's own levels
  assign pin_in_out = (pin_oe_in & pin_out_in)
    | (~pin_oe_in & {idle_in[SDIO_W-1:1], data_bit});
  always @(posedge pin_out_in[SDIO_LINE_SCLK] or posedge clear_in) begin
    if (clear_in) begin
      rises_out <= 0;
      tx_seen_out <= '0;
    end else begin
      tx_seen_out <= {pin_out_in[SDIO_LINE_SDAT], tx_seen_out[SDIO_W-1:1]};
      rises_out <= rises_out + 1;
    end
  end
  // Next bit right after each rise; past the frame the line flips
  assign data_bit = (rises_out < SDIO_W) ? rx_byte_in[rises_out[2:0]]
    : ~rx_byte_in[SDIO_W-1];
endmodule

// >>> verification/simple_dio_port_with_serial_shift_test.sv
`timescale 1ns/1ns
module simple_dio_port_with_serial_shift_test;
  import sdio_pkg::*;
  logic clock_in = 0;
  logic rst_b_in = 0;
  logic wr_in = 0;
  logic rd_in = 0;
  logic clear = 0;
  logic [11:0] addr_in = '0;
  logic [1:0] be_in = '0;
  logic [15:0] wdata_in = '0;
  logic [15:0] rdata_out;
  logic [15:0] rd_val;
  logic rvalid_out;
  logic shift_busy_out;
  logic [7:0] cfg_owns_in = '0;
  logic [7:0] cfg_oe_in = '0;
  logic [7:0] rx_byte = '0;
  logic [7:0] idle = 8'h5A;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_out;
  logic [7:0] tx_seen;
  int rises;
  int miscompares = 0;
  int comparisons = 0;

  initial forever #25 clock_in = ~clock_in;

  sdio_port u_dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .be_in(be_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .cfg_owns_in(cfg_owns_in), .cfg_oe_in(cfg_oe_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .shift_busy_out(shift_busy_out));

  sdio_line_model u_lines (
    .pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .pin_in_out(pin_in),
    .clear_in(clear), .rx_byte_in(rx_byte), .idle_in(idle),
    .tx_seen_out(tx_seen), .rises_out(rises));

  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", comparisons,
      miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic hang;
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    give_verdict;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [1:0] b, logic [15:0] d);
    @(negedge clock_in);
    addr_in = a;
    be_in = b;
    wdata_in = d;
    wr_in = 1;
    @(negedge clock_in);
    wr_in = 0;
  endtask

  task automatic rd(logic [11:0] a);
    int n = 0;
    @(negedge clock_in);
    addr_in = a;
    rd_in = 1;
    @(negedge clock_in);
    rd_in = 0;
    while (rvalid_out !== 1'b1 && n < 4) begin
      @(negedge clock_in);
      n++;
    end
    if (n == 4) hang;
    rd_val = rdata_out;
  endtask

  task automatic t_reset;
    chk({pin_oe_out, pin_out}, 16'h0000);
    chk({15'h0, shift_busy_out}, 16'h0000);
    $display("reset test ended");
  endtask

  task automatic t_parallel;
    wr(SDIO_OFS_CTRL, 2'b01, 16'h000F);
    wr(SDIO_OFS_OUT, 2'b01, 16'h00A5);
    repeat (3) @(negedge clock_in);
    chk({pin_oe_out, pin_out}, 16'h0FA5);
    cfg_owns_in = 8'hF0;
    cfg_oe_in = 8'h30;
    repeat (3) @(negedge clock_in);
    chk({8'h0, pin_oe_out}, 16'h003F);
    rd(SDIO_OFS_PIN_IN);
    chk({8'h0, rd_val[7:0]}, {8'h0, 8'h25 | (idle & 8'hC0)});
    cfg_owns_in = '0;
    $display("parallel test ended");
  endtask

  task automatic t_regs;
    logic [11:0] a [3] = '{SDIO_OFS_OUT, SDIO_OFS_CTRL, 12'h020};
    foreach (a[i]) begin
      rd(a[i]);
      chk(rd_val, 16'h0000);
    end
    $display("register test ended");
  endtask

  task automatic t_toggle;
    wr(SDIO_OFS_CTRL, 2'b11, 16'h080F);
    repeat (3) @(negedge clock_in);
    chk({8'h0, pin_out}, 16'h00B5);
    wr(SDIO_OFS_CTRL, 2'b11, 16'h080F);
    repeat (3) @(negedge clock_in);
    chk({8'h0, pin_out}, 16'h00A5);
    // Go without auto-shift must not start anything
    wr(SDIO_OFS_CTRL, 2'b11, 16'h010F);
    repeat (2) @(negedge clock_in);
    chk({15'h0, shift_busy_out}, 16'h0000);
    $display("toggle test ended");
  endtask

  // Line 0 left undriven so the far side can feed serial data
  task automatic t_shift(logic rate, int per, logic [7:0] tx,
      logic [7:0] rx);
    int n;
    logic [15:0] ctl;
    ctl = {5'h0, rate, 2'b11, 8'h10};
    rx_byte = rx;
    clear = 1;
    wr(SDIO_OFS_OUT, 2'b10, {tx, 8'h00});
    clear = 0;
    wr(SDIO_OFS_CTRL, 2'b11, ctl);
    @(negedge clock_in);
    chk({15'h0, shift_busy_out}, 16'h0001);
    wr(SDIO_OFS_CTRL, 2'b11, ctl);
    n = 3;
    while (shift_busy_out === 1'b1 && n < 4000) begin
      @(negedge clock_in);
      n++;
    end
    if (n == 4000) hang;
    chk({15'h0, n >= 8 * per - 2 && n <= 8 * per + 3}, 16'h1);
    chk({8'h0, tx_seen}, {8'h0, tx});
    chk(16'(rises), 16'h0008);
    // Pin flop lags the shift clock by one cycle
    @(negedge clock_in);
    chk({15'h0, pin_out[SDIO_LINE_SCLK]}, 16'h0000);
    rd(SDIO_OFS_SHIFT_IN);
    chk({8'h0, rd_val[7:0]}, {8'h0, rx});
    $display("shift test ended");
  endtask

  initial begin
    // Edge on clear so the far side starts from known counts
    #1 clear = 1;
    repeat (3) @(negedge clock_in);
    rst_b_in = 1;
    clear = 0;
    repeat (4) @(negedge clock_in);
    t_reset;
    t_parallel;
    t_regs;
    t_toggle;
    t_shift(1'b0, 24, 8'h96, 8'h3C);
    t_shift(1'b1, 200, 8'h01, 8'h80);
    give_verdict;
  end
endmodule
